//--- rtl/aging_mirror_consts.svh
// Offsets, field positions, reset values and timing counts for the
// aging and mirror configuration registers. Definitions only.
`ifndef AGING_MIRROR_CONSTS_SVH
`define AGING_MIRROR_CONSTS_SVH

`define AGING_OFFSET 8'h06
`define AGING_LAST 8'h09
`define MIRROR_OFFSET 8'h10
`define MIRROR_LAST 8'h11
`define AGING_SEL_BIT 20
`define AGING_LIFE_MSB 19
`define LIFE_DEFAULT 20'h0012C
`define MIRROR_EN_BIT 15
`define MIRROR_EXCL_BIT 14
`define MIRROR_RSV_MSB 5
`define MIRROR_PORT_MSB 3
`define AGE_FIXED_SEC 20'h0012C
`define CLK_HZ 100000000
`define TICK_SEC 1

`endif

//--- rtl/aging_mirror_pkg.sv
// Types shared by the aging and mirror configuration block.
// Assumes the constants header is compiled alongside.
package aging_mirror_pkg;

typedef struct packed {
   logic enable;
   logic [19:0] period_sec;
} aging_cfg_type;

typedef struct packed {
   logic enable;
   logic exclusive;
   logic [3:0] port;
} mirror_cfg_type;

endpackage

//--- rtl/second_tick.sv
// One-cycle enable pulse once per second derived from the core clock.
// Assumes sys_clk runs at the rate the count parameter is set for.
`timescale 1ns/10ps
`default_nettype none

module second_tick
#(
   parameter int unsigned CYCLES = 100000000
)
(
   input wire logic sys_clk, // Core clock
   input wire logic arst_n, // Async reset, active low
   output logic tick // One-cycle pulse each second
);

   logic [31:0] count_r;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         count_r <= 32'h00000000;
         tick <= 1'b0;
      end
      else if (count_r == 32'(CYCLES - 1))
      begin
         count_r <= 32'h00000000;
         tick <= 1'b1;
      end
      else
      begin
         count_r <= count_r + 32'h00000001;
         tick <= 1'b0;
      end
   end

endmodule

`default_nettype wire

//--- rtl/switch_aging_mirror_config.sv
// Aging period and mirror capture configuration registers of the switch
// management page, with a one-second tick for the aging engine.
// Assumes a byte-wide paged register port already decoded to this page.
`timescale 1ns/10ps
`default_nettype none
`include "aging_mirror_consts.svh"

module switch_aging_mirror_config
#(
   parameter int unsigned TICK_CYCLES = `CLK_HZ * `TICK_SEC
)
(
   input wire logic sys_clk, // Core clock, 100 MHz
   input wire logic arst_n, // Async reset, active low
   input wire logic [7:0] reg_addr, // Byte address within the page
   input wire logic reg_wr, // Byte write strobe
   input wire logic reg_rd, // Byte read strobe
   input wire logic [7:0] reg_wdata, // Write data byte
   output logic [7:0] reg_rdata, // Read data byte, valid cycle after reg_rd
   output logic reg_rvalid, // Read data valid pulse
   output aging_mirror_pkg::aging_cfg_type aging_cfg, // Effective aging setup
   output logic age_tick, // One-second pulse for the aging engine
   output aging_mirror_pkg::mirror_cfg_type mirror_cfg // Mirror setup
);

   // Stored register contents and their decoded forms
   logic age_sel_r;
   logic [19:0] life_r;
   logic [7:0] mirror_lo_r;
   logic [7:0] mirror_hi_r;
   logic tick_w;
   logic wr_life0;
   logic wr_life1;
   logic wr_life2;
   logic wr_mirror_lo;
   logic wr_mirror_hi;
   logic [7:0] rdata_nxt;
   aging_mirror_pkg::aging_cfg_type aging_nxt;
   aging_mirror_pkg::mirror_cfg_type mirror_nxt;

   // Byte lane of a register from its base offset
   function automatic logic [1:0] lane(input logic [7:0] addr, input logic [7:0] base);
      logic [7:0] d;
      d = addr - base;
      lane = d[1:0];
   endfunction

   // True when addr is byte n of the register spanning first to last
   function automatic logic byte_hit(input logic [7:0] addr, input logic [7:0] first,
      input logic [7:0] last, input logic [1:0] n);
      byte_hit = (addr >= first) && (addr <= last) && (lane(addr, first) == n);
   endfunction

   // Divider for the one-second enable
   second_tick #(.CYCLES(TICK_CYCLES)) u_tick
   (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .tick(tick_w)
   );

   // Per-byte write enables; byte 3 of the aging register has none
   always_comb
   begin
      wr_life0 = 1'b0;
      wr_life1 = 1'b0;
      wr_life2 = 1'b0;
      wr_mirror_lo = 1'b0;
      wr_mirror_hi = 1'b0;
      if (reg_wr)
      begin
         if (byte_hit(reg_addr, `AGING_OFFSET, `AGING_LAST, 2'h0))
            wr_life0 = 1'b1;
         else if (byte_hit(reg_addr, `AGING_OFFSET, `AGING_LAST, 2'h1))
            wr_life1 = 1'b1;
         else if (byte_hit(reg_addr, `AGING_OFFSET, `AGING_LAST, 2'h2))
            wr_life2 = 1'b1;
         else if (byte_hit(reg_addr, `MIRROR_OFFSET, `MIRROR_LAST, 2'h0))
            wr_mirror_lo = 1'b1;
         else if (byte_hit(reg_addr, `MIRROR_OFFSET, `MIRROR_LAST, 2'h1))
            wr_mirror_hi = 1'b1;
      end
   end

   // Lifetime bytes; the full 20-bit range is stored unchecked
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         life_r <= `LIFE_DEFAULT;
      else if (wr_life0)
         life_r[7:0] <= reg_wdata;
      else if (wr_life1)
         life_r[15:8] <= reg_wdata;
      else if (wr_life2)
         life_r[19:16] <= reg_wdata[3:0];
   end

   // Period select; the bits above it read back as zero
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         age_sel_r <= 1'b0;
      else if (wr_life2)
         age_sel_r <= reg_wdata[`AGING_SEL_BIT - 16];
   end

   // Mirror low byte: capture port, reserved bits 5:4 kept for read-back only
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         mirror_lo_r <= 8'h00;
      else if (wr_mirror_lo)
         mirror_lo_r <= reg_wdata;
   end

   // Mirror high byte: global enable and exclusive capture
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         mirror_hi_r <= 8'h00;
      else if (wr_mirror_hi)
         mirror_hi_r <= reg_wdata;
   end

   // Read strobe answered one cycle later
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         reg_rvalid <= 1'b0;
      else
         reg_rvalid <= reg_rd;
   end

   // Byte selected by the read address; unmapped and reserved bytes read zero
   always_comb
   begin
      rdata_nxt = 8'h00;
      if (reg_addr == `AGING_OFFSET)
         rdata_nxt = life_r[7:0];
      else if (reg_addr == `AGING_OFFSET + 8'h01)
         rdata_nxt = life_r[15:8];
      else if (reg_addr == `AGING_OFFSET + 8'h02)
         rdata_nxt = {3'h0, age_sel_r, life_r[19:16]};
      else if (reg_addr == `AGING_LAST)
         rdata_nxt = 8'h00;
      else if (reg_addr == `MIRROR_OFFSET)
         rdata_nxt = mirror_lo_r;
      else if (reg_addr == `MIRROR_LAST)
         rdata_nxt = mirror_hi_r;
      else
         rdata_nxt = 8'h00;
   end

   // Read data is captured on a read and held until the next one
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= rdata_nxt;
   end

   // Effective aging period: fixed default, programmed, or off
   always_comb
   begin
      aging_nxt.enable = 1'b1;
      aging_nxt.period_sec = `AGE_FIXED_SEC;
      if (age_sel_r)
      begin
         aging_nxt.period_sec = life_r;
         aging_nxt.enable = (life_r != 20'h00000);
      end
   end

   // Registered effective period for the aging engine
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         aging_cfg <= '0;
      else
         aging_cfg <= aging_nxt;
   end

   // Second tick retimed so that the output leaves a flip-flop
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         age_tick <= 1'b0;
      else
         age_tick <= tick_w;
   end

   // Mirror fields; reserved and spare bits do not reach the mirror logic
   always_comb
   begin
      mirror_nxt.enable = mirror_hi_r[`MIRROR_EN_BIT - 8];
      mirror_nxt.exclusive = mirror_hi_r[`MIRROR_EXCL_BIT - 8];
      mirror_nxt.port = mirror_lo_r[`MIRROR_PORT_MSB:0];
   end

   // Registered mirror setup
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         mirror_cfg <= '0;
      else
         mirror_cfg <= mirror_nxt;
   end

endmodule

`default_nettype wire

//--- verif/switch_aging_mirror_config_chk.sv
// Port checker for the aging and mirror configuration block.
// Assumes one clock domain and the tick count handed on by the bind.
`timescale 1ns/10ps
`default_nettype none
module switch_aging_mirror_config_chk
#(
   parameter int unsigned TICK_CYCLES = 10
)
(
   input wire logic sys_clk, // Core clock
   input wire logic arst_n, // Async reset, active low
   input wire logic [7:0] reg_addr, // Byte address
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   input wire logic [7:0] reg_wdata, // Write byte
   input wire logic [7:0] reg_rdata, // Read byte
   input wire logic reg_rvalid, // Read valid
   input wire aging_mirror_pkg::aging_cfg_type aging_cfg, // Aging setup
   input wire logic age_tick, // Second pulse
   input wire aging_mirror_pkg::mirror_cfg_type mirror_cfg // Mirror setup
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!arst_n);
logic [31:0] gap_r;
// Cycles since the last tick, zero until the first one
always_ff @(posedge sys_clk or negedge arst_n)
   if (!arst_n)
      gap_r <= 32'h0;
   else
      gap_r <= age_tick ? 32'h1 : gap_r + 32'(gap_r != 32'h0);
sel_default_a: assert property (reg_wr && reg_addr == 8'h08 && !reg_wdata[4]
   |-> ##2 aging_cfg == 21'h10012C) else $error("default period not applied");
sel_program_a: assert property (reg_wr && reg_addr == 8'h08 && reg_wdata[4]
   |-> ##2 aging_cfg.period_sec[19:16] == $past(reg_wdata[3:0], 2))
   else $error("programmed period not applied");
zero_off_a: assert property (aging_cfg.period_sec == 20'h0 |-> !aging_cfg.enable)
   else $error("zero period left aging on");
port_follow_a: assert property (reg_wr && reg_addr == 8'h10
   |-> ##2 mirror_cfg.port == $past(reg_wdata[3:0], 2)) else $error("capture port wrong");
mirror_bits_a: assert property (reg_wr && reg_addr == 8'h11
   |-> ##2 {mirror_cfg.enable, mirror_cfg.exclusive} == $past(reg_wdata[7:6], 2))
   else $error("mirror enable bits wrong");
mirror_hold_a: assert property ((!reg_wr)[*2] |=> $stable(mirror_cfg))
   else $error("mirror setup moved without a write");
read_valid_a: assert property (reg_rvalid == $past(reg_rd))
   else $error("read valid timing wrong");
rsv_read_a: assert property (reg_rd && reg_addr == 8'h09 |=> reg_rdata == 8'h00)
   else $error("reserved byte not zero");
tick_gap_a: assert property (age_tick && gap_r != 32'h0 |-> gap_r == TICK_CYCLES)
   else $error("tick spacing wrong");
cover property (age_tick);
cover property (reg_wr && reg_addr == 8'h08 && reg_wdata[4]);
cover property (mirror_cfg.enable && mirror_cfg.exclusive);
endmodule
bind switch_aging_mirror_config switch_aging_mirror_config_chk #(.TICK_CYCLES(TICK_CYCLES)) chk
   (.sys_clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
   .aging_cfg, .age_tick, .mirror_cfg);
`default_nettype wire

//--- verif/switch_aging_mirror_config_test.sv
// Self-checking bench for the aging and mirror configuration block.
// Assumes a tick count of 10 cycles for simulation.
`timescale 1ns/10ps
`default_nettype none
module switch_aging_mirror_config_test;
logic sys_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, reg_rvalid, age_tick;
logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
aging_mirror_pkg::aging_cfg_type aging_cfg;
aging_mirror_pkg::mirror_cfg_type mirror_cfg;
int n_fail = 0, checked = 0, ticks;
always #5 sys_clk = ~sys_clk;
switch_aging_mirror_config #(.TICK_CYCLES(10)) dut (.sys_clk, .arst_n, .reg_addr, .reg_wr,
   .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .aging_cfg, .age_tick, .mirror_cfg);
task conclude;
   if (n_fail == 0 && checked > 0)
      $display("ALL TESTS PASSED");
   else
      $display("TESTS FAILED");
   $finish;
endtask
task chk(input logic [20:0] s, e);
   checked++;
   if (s !== e)
   begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, s, e);
   end
endtask
task acc(input logic w, input logic [7:0] a, d);
   @(posedge sys_clk);
   reg_wr <= w;
   reg_rd <= !w;
   reg_addr <= a;
   reg_wdata <= d;
   @(posedge sys_clk);
   reg_wr <= 0;
   reg_rd <= 0;
   #1;
endtask
task rd(input logic [7:0] a, e);
   acc(0, a, 8'h00);
   chk(21'(reg_rvalid), 21'h1);
   chk(21'(reg_rdata), 21'(e));
endtask
task settle;
   repeat (2) @(posedge sys_clk);
   #1;
endtask
// Writes lifetime and select bytes, low byte first
task wage(input logic [23:0] v);
   for (int i = 0; i < 3; i++)
      acc(1, 8'(6 + i), v[8 * i +: 8]);
   settle;
endtask
task t_reset;
   rd(8'h06, 8'h2C);
   rd(8'h07, 8'h01);
   rd(8'h08, 8'h00);
   rd(8'h10, 8'h00);
   rd(8'h11, 8'h00);
   chk(aging_cfg, 21'h10012C);
endtask
task t_age;
   wage(24'hFFFFFF);
   rd(8'h08, 8'h1F);
   chk(aging_cfg, 21'h1FFFFF);
   wage(24'h0F1234);
   chk(aging_cfg, 21'h10012C);
   wage(24'h1ABCDE);
   chk(aging_cfg, 21'h1ABCDE);
   wage(24'h100000);
   chk(21'(aging_cfg.enable), 21'h0);
   acc(1, 8'h09, 8'hFF);
   rd(8'h09, 8'h00);
endtask
task t_mirror;
   acc(1, 8'h10, 8'h3B);
   acc(1, 8'h11, 8'hC0);
   settle;
   chk(21'(mirror_cfg), 21'h3B);
   rd(8'h10, 8'h3B);
   acc(1, 8'h11, 8'h40);
   acc(1, 8'h10, 8'h05);
   settle;
   chk(21'(mirror_cfg), 21'h15);
endtask
task t_tick;
   ticks = 0;
   repeat (40)
   begin
      @(posedge sys_clk);
      #1;
      ticks += int'(age_tick);
   end
   chk(21'(ticks), 21'h4);
endtask
initial
begin
   repeat (6) @(posedge sys_clk);
   arst_n <= 1;
   t_reset;
   t_age;
   t_mirror;
   t_tick;
   conclude;
end
initial
begin
   #20000;
   n_fail++;
   conclude;
end
endmodule
`default_nettype wire
